/* hdl/srst_ctrl.sv */
// software reset controller: register port, reset sequencer, output gating
`timescale 1ns/1ps
module srst_ctrl #(
    parameter int STRAP_W = 4,                    // configuration pins
    parameter int HOLD    = srst_pkg::HOLD_CYC    // reset hold in cycles
) (
    input  wire logic               sys_clk,          // 40 MHz clock
    input  wire logic               rstn,             // synchronous reset, active low
    input  wire logic [15:0]        reg_addr,         // management register address
    input  wire logic               reg_wr,           // write strobe, one cycle
    input  wire logic               reg_rd,           // read strobe, one cycle
    input  wire logic [15:0]        reg_wdata,        // write data
    output logic      [15:0]        reg_rdata,        // read data
    output logic                    reg_rvalid,       // read data valid pulse
    input  wire logic [STRAP_W-1:0] strap_pins,       // configuration pin levels
    input  wire logic               gen_clk_sel_125,  // general clock set to 125 MHz
    input  wire logic               ref_clk_enable,   // reference clock output enabled
    input  wire logic               gen_clk_enable,   // general clock output enabled
    input  wire logic [7:0]         mac_rxd_in,       // core receive data
    input  wire logic               mac_rx_ctl_in,    // core receive control
    input  wire logic               mac_rxc_in,       // core receive clock level
    output logic      [7:0]         mac_rxd_out,      // MAC-side receive data
    output logic                    mac_rx_ctl_out,   // MAC-side receive control
    output logic                    mac_rxc_out,      // MAC-side receive clock
    output logic                    core_rst_out,     // PHY core logic reset
    output logic                    core_regs_rst_out,// PHY core registers reset
    output logic                    sub_regs_rst_out, // subsystem registers reset
    output logic                    mac_if_rst_out,   // MAC interface block reset
    output logic                    cmu_rst_out,      // clock multiplier reset
    output logic                    ref_clk_avail,    // reference clock output on
    output logic                    gen_clk_avail,    // general clock output on
    output logic                    xtal_en,          // crystal oscillator enable
    output logic      [STRAP_W-1:0] strap_latched     // latched strap values
);
    srst_seq_if seq ();

    srst_hold_timer #(
        .HOLD (HOLD)
    ) u_timer (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .seq     (seq)
    );

    srst_pkg::srst_state_t state_r;
    srst_pkg::srst_state_t state_nxt;
    logic                  start_nxt;
    logic                  start_r;

    logic [14:0]        ctrl_r;
    logic [14:0]        ctrl_nxt;
    logic               reload_en_r;
    logic               reload_en_nxt;
    logic [STRAP_W-1:0] strap_r;
    logic [STRAP_W-1:0] strap_nxt;
    logic               strap_ok_r;
    logic               strap_ok_nxt;

    logic               wr_ctrl;
    logic               wr_trig;
    logic               wr_rel;

    // write decode; writes land only while no reset is running
    assign wr_ctrl = reg_wr && (reg_addr == srst_pkg::ADDR_CORE_CTRL);
    assign wr_trig = reg_wr && (reg_addr == srst_pkg::ADDR_SUB_TRIG);
    assign wr_rel  = reg_wr && (reg_addr == srst_pkg::ADDR_RELOAD_EN);

    // sequencer: pick the reset kind from the write, hold until timer done
    always_comb begin
        state_nxt = state_r;
        start_nxt = 1'b0;
        case (state_r)
            srst_pkg::S_IDLE: begin
                if (strap_ok_r && wr_trig && reg_wdata[srst_pkg::SUB_TRIG_BIT]) begin
                    // enable must already be set when the trigger lands
                    state_nxt = reload_en_r ? srst_pkg::S_RELOAD : srst_pkg::S_SUB;
                    start_nxt = 1'b1;
                end else if (strap_ok_r && wr_ctrl && reg_wdata[srst_pkg::CORE_SRST_BIT]) begin
                    state_nxt = srst_pkg::S_CORE;
                    start_nxt = 1'b1;
                end
            end
            srst_pkg::S_CORE,
            srst_pkg::S_SUB,
            srst_pkg::S_RELOAD: begin
                if (seq.done) begin
                    state_nxt = srst_pkg::S_IDLE;
                end
            end
            default: begin
                state_nxt = srst_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r <= srst_pkg::S_IDLE;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_r <= start_nxt;
        end
    end

    assign seq.start = start_r;

    // registers and strap latch; defaults are taken from the latched straps
    always_comb begin
        ctrl_nxt      = ctrl_r;
        reload_en_nxt = reload_en_r;
        strap_nxt     = strap_r;
        strap_ok_nxt  = 1'b1;
        if (!strap_ok_r) begin
            // first cycle after hardware reset release: catch the straps
            strap_nxt = strap_pins;
            ctrl_nxt  = srst_pkg::CORE_CTRL_RST;
            ctrl_nxt[srst_pkg::CTRL_STRAP_POS +: STRAP_W] = strap_pins;
        end else if (state_r == srst_pkg::S_IDLE) begin
            // writing 0 to a self-clearing bit does nothing
            if (wr_ctrl) begin
                ctrl_nxt = reg_wdata[14:0];
            end
            if (wr_rel) begin
                reload_en_nxt = reg_wdata[srst_pkg::RELOAD_EN_BIT];
            end
        end else if (start_r) begin
            if (state_r == srst_pkg::S_RELOAD) begin
                strap_nxt = strap_pins;
                ctrl_nxt  = srst_pkg::CORE_CTRL_RST;
                ctrl_nxt[srst_pkg::CTRL_STRAP_POS +: STRAP_W] = strap_pins;
                reload_en_nxt = srst_pkg::RELOAD_EN_RST;
            end else begin
                // core and plain subsystem resets reuse the old straps
                ctrl_nxt = srst_pkg::CORE_CTRL_RST;
                ctrl_nxt[srst_pkg::CTRL_STRAP_POS +: STRAP_W] = strap_r;
                if (state_r == srst_pkg::S_SUB) begin
                    reload_en_nxt = srst_pkg::RELOAD_EN_RST;
                end
                // core reset leaves the subsystem bit untouched
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_r      <= srst_pkg::CORE_CTRL_RST;
            reload_en_r <= srst_pkg::RELOAD_EN_RST;
            strap_r     <= '0;
            strap_ok_r  <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            reload_en_r <= reload_en_nxt;
            strap_r     <= strap_nxt;
            strap_ok_r  <= strap_ok_nxt;
        end
    end

    // read port; self-clearing bits show a running reset, 0 once done
    logic [15:0] rdata_nxt;
    logic        core_busy;
    logic        sub_busy;

    assign core_busy = (state_r == srst_pkg::S_CORE);
    assign sub_busy  = (state_r == srst_pkg::S_SUB) || (state_r == srst_pkg::S_RELOAD);

    always_comb begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            srst_pkg::ADDR_CORE_CTRL: begin
                rdata_nxt = {core_busy, ctrl_r};
            end
            srst_pkg::ADDR_SUB_TRIG: begin
                rdata_nxt[srst_pkg::SUB_TRIG_BIT] = sub_busy;
            end
            srst_pkg::ADDR_RELOAD_EN: begin
                rdata_nxt[srst_pkg::RELOAD_EN_BIT] = reload_en_r;
            end
            default: begin
                rdata_nxt = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd ? rdata_nxt : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    // reset and clock outputs, computed from the next state so they come
    // straight from flip-flops and line up with the sequencer state
    logic any_nxt;
    logic sub_nxt;
    logic rel_nxt;
    logic core_nxt;

    assign rel_nxt  = (state_nxt == srst_pkg::S_RELOAD);
    assign sub_nxt  = (state_nxt == srst_pkg::S_SUB) || rel_nxt;
    assign core_nxt = (state_nxt == srst_pkg::S_CORE);
    assign any_nxt  = core_nxt || sub_nxt;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            // hardware reset: everything held, output clocks stopped
            core_rst_out      <= 1'b1;
            core_regs_rst_out <= 1'b1;
            sub_regs_rst_out  <= 1'b1;
            mac_if_rst_out    <= 1'b1;
            cmu_rst_out       <= 1'b1;
            ref_clk_avail     <= 1'b0;
            gen_clk_avail     <= 1'b0;
            xtal_en           <= 1'b1;
        end else begin
            core_rst_out      <= any_nxt;
            core_regs_rst_out <= any_nxt;
            sub_regs_rst_out  <= sub_nxt;
            mac_if_rst_out    <= sub_nxt;
            cmu_rst_out       <= any_nxt && !gen_clk_sel_125;
            // reload reset stops the reference clock, and the general clock only when set to 125 MHz
            ref_clk_avail     <= ref_clk_enable && !rel_nxt;
            gen_clk_avail     <= gen_clk_enable && !(rel_nxt && gen_clk_sel_125);
            xtal_en           <= 1'b1;
        end
    end

    // MAC-side receive path parks idle whenever the core is in reset
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mac_rxd_out    <= 8'h00;
            mac_rx_ctl_out <= 1'b0;
            mac_rxc_out    <= 1'b1;
        end else if (any_nxt) begin
            mac_rxd_out    <= 8'h00;
            mac_rx_ctl_out <= 1'b0;
            mac_rxc_out    <= 1'b1;
        end else begin
            mac_rxd_out    <= mac_rxd_in;
            mac_rx_ctl_out <= mac_rx_ctl_in;
            mac_rxc_out    <= mac_rxc_in;
        end
    end

    assign strap_latched = strap_r;
endmodule

/* hdl/srst_pkg.sv */
// constants, states and register map of the software reset controller
// Notes on behaviour
// - reload reset mirrors hardware reset, oscillator kept
// - reload reset relatches strap pins as defaults
// - reload reset resets MAC block and core
// - multiplier kept only when general clock 125MHz
// - reload reset clears its own enable bit
// - reload reset stops reference and 125MHz clocks
// - subsystem trigger starts reset, clears itself
// - plain subsystem reset: registers, MAC block, core
// - plain subsystem reset reuses earlier latched straps
// - plain subsystem reset keeps output clocks running
// - core soft reset bit starts core reset
// - core reset keeps subsystem registers intact
// - core reset leaves MAC block alone
// - core reset reuses earlier latched straps
// - core reset keeps output clocks running
// - core in reset: MAC outputs low, rx clock high
package srst_pkg;
    localparam int          CLK_MHZ        = 40;
    localparam int          HOLD_NS        = 1000;   // minimum reset pulse width; the timer hold, two cycles shorter than the pulse
    localparam int          HOLD_CYC       = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int          CNT_W          = $clog2(HOLD_CYC + 1);

    localparam logic [15:0] ADDR_CORE_CTRL = 16'h0000;
    localparam logic [15:0] ADDR_SUB_TRIG  = 16'hff0c;
    localparam logic [15:0] ADDR_RELOAD_EN = 16'hff0d;

    localparam int          CORE_SRST_BIT  = 15;     // core_soft_reset field
    localparam int          SUB_TRIG_BIT   = 0;
    localparam int          RELOAD_EN_BIT  = 0;
    localparam int          CTRL_STRAP_POS = 0;      // straps land in low control bits

    localparam logic [14:0] CORE_CTRL_RST  = 15'h0000;
    localparam logic        RELOAD_EN_RST  = 1'b0;

    typedef enum logic [3:0] {
        S_IDLE   = 4'b0001,
        S_CORE   = 4'b0010,
        S_SUB    = 4'b0100,
        S_RELOAD = 4'b1000
    } srst_state_t;
endpackage

/* hdl/srst_seq_if.sv */
// handshake between the reset sequencer and its hold timer
`timescale 1ns/1ps
interface srst_seq_if;
    logic start;   // one-cycle pulse: begin a hold interval
    logic busy;    // timer counting
    logic done;    // one-cycle pulse: interval over

    modport ctl (output start, input busy, input done);
    modport tmr (input start, output busy, output done);
endinterface

/* hdl/srst_hold_timer.sv */
// fixed-length hold timer for one reset pulse
`timescale 1ns/1ps
module srst_hold_timer #(
    parameter int HOLD = srst_pkg::HOLD_CYC       // cycles a reset is held
) (
    input  wire logic  sys_clk,                   // 40 MHz clock
    input  wire logic  rstn,                      // synchronous reset, active low
    srst_seq_if.tmr    seq                        // start / busy / done
);
    localparam logic [srst_pkg::CNT_W-1:0] LAST = srst_pkg::CNT_W'(HOLD - 1);

    logic [srst_pkg::CNT_W-1:0] cnt_r;
    logic [srst_pkg::CNT_W-1:0] cnt_nxt;
    logic                       busy_r;
    logic                       busy_nxt;
    logic                       done_r;
    logic                       done_nxt;

    // count from start to the last cycle, then pulse done once
    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (busy_r) begin
            if (cnt_r == LAST) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end else if (seq.start) begin
            busy_nxt = 1'b1;
            cnt_nxt  = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign seq.busy = busy_r;
    assign seq.done = done_r;
endmodule

/* dv/srst_ctrl_checker.sv */
// port assertions for the software reset controller
`timescale 1ns/1ps
module srst_ctrl_checker #(
    parameter int HOLD = srst_pkg::HOLD_CYC     // reset hold in cycles
) (
    input wire logic        sys_clk,            // clock
    input wire logic        rstn,               // sync reset, active low
    input wire logic [15:0] reg_addr,           // register address
    input wire logic        reg_wr,             // write strobe
    input wire logic [15:0] reg_wdata,          // write data
    input wire logic        gen_clk_sel_125,    // general clock at 125 MHz
    input wire logic        ref_clk_enable,     // reference clock enable
    input wire logic [7:0]  mac_rxd_out,        // MAC receive data
    input wire logic        mac_rx_ctl_out,     // MAC receive control
    input wire logic        mac_rxc_out,        // MAC receive clock
    input wire logic        core_rst_out,       // core logic reset
    input wire logic        core_regs_rst_out,  // core registers reset
    input wire logic        sub_regs_rst_out,   // subsystem registers reset
    input wire logic        mac_if_rst_out,     // MAC block reset
    input wire logic        cmu_rst_out,        // multiplier reset
    input wire logic        ref_clk_avail,      // reference clock on
    input wire logic        xtal_en             // oscillator enable
);
    // pulse spans the hold plus the start and the timer hand-off edges
    localparam int LEN = HOLD + 1;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    mac_idle_a: assert property (
        core_rst_out |-> mac_rxd_out == 8'h00 && !mac_rx_ctl_out && mac_rxc_out)
        else $error("mac outputs not idle in core reset");
    sub_start_a: assert property (
        reg_wr && reg_addr == srst_pkg::ADDR_SUB_TRIG && reg_wdata[0] && !core_rst_out
        |=> sub_regs_rst_out && mac_if_rst_out && core_rst_out) else $error("no subsystem reset");
    core_start_a: assert property (
        reg_wr && reg_addr == srst_pkg::ADDR_CORE_CTRL && reg_wdata[15] && !core_rst_out
        |=> core_rst_out && core_regs_rst_out && !sub_regs_rst_out) else $error("bad core reset");
    zero_ignored_a: assert property (
        reg_wr && reg_addr == srst_pkg::ADDR_SUB_TRIG && !reg_wdata[0] && !core_rst_out
        |=> !core_rst_out) else $error("zero write started a reset");
    pulse_ends_a: assert property (
        $rose(core_rst_out) |-> ##LEN core_rst_out ##1 !core_rst_out)
        else $error("reset pulse length wrong");
    cmu_choice_a: assert property (
        $past(rstn) && core_rst_out |-> cmu_rst_out == !$past(gen_clk_sel_125))
        else $error("multiplier reset wrong");
    mac_kept_a: assert property (
        core_rst_out && !sub_regs_rst_out |-> !mac_if_rst_out) else $error("MAC block reset");
    sub_full_a: assert property (
        sub_regs_rst_out |-> core_regs_rst_out && mac_if_rst_out) else $error("partial reset");
    ref_drop_a: assert property (
        $fell(ref_clk_avail) && $past(ref_clk_enable) |-> sub_regs_rst_out)
        else $error("reference clock dropped");
    xtal_kept_a: assert property (xtal_en) else $error("oscillator off");

    cover property ($rose(core_rst_out) && !sub_regs_rst_out);
    cover property (sub_regs_rst_out && !ref_clk_avail);
    cover property ($rose(sub_regs_rst_out) && ref_clk_avail);
endmodule

bind srst_ctrl srst_ctrl_checker #(.HOLD(HOLD)) chk (
    .sys_clk, .rstn, .reg_addr, .reg_wr, .reg_wdata, .gen_clk_sel_125, .ref_clk_enable,
    .mac_rxd_out, .mac_rx_ctl_out, .mac_rxc_out, .core_rst_out, .core_regs_rst_out,
    .sub_regs_rst_out, .mac_if_rst_out, .cmu_rst_out, .ref_clk_avail, .xtal_en);

/* dv/srst_host.sv */
// host software model driving the management register port
`timescale 1ns/1ps
module srst_host (
    input  wire logic        sys_clk,     // clock
    output logic      [15:0] reg_addr,    // register address
    output logic             reg_wr,      // write strobe
    output logic             reg_rd,      // read strobe
    output logic      [15:0] reg_wdata,   // write data
    input  wire logic [15:0] reg_rdata,   // read data
    input  wire logic        reg_rvalid   // read data valid
);
    // idle bus shows inverted last values so stale data never looks live
    initial begin
        reg_addr  = 16'hffff;
        reg_wdata = 16'hffff;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge sys_clk);
        #2;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // data is taken in the cycle the valid pulse stands
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge sys_clk);
        #2;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #2;
            n++;
        end
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the software reset controller
`timescale 1ns/1ps
module testbench;
    localparam int HOLD = 4;   // short hold keeps the run brief
    logic sys_clk, rstn, reg_wr, reg_rd, reg_rvalid, gen_clk_sel_125, ref_clk_enable;
    logic gen_clk_enable, mac_rx_ctl_in, mac_rxc_in, mac_rx_ctl_out, mac_rxc_out;
    logic core_rst_out, core_regs_rst_out, sub_regs_rst_out, mac_if_rst_out, cmu_rst_out;
    logic ref_clk_avail, gen_clk_avail, xtal_en;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, wdat;
    logic [7:0]  mac_rxd_in, mac_rxd_out;
    logic [3:0]  strap_pins, strap_latched, latched_m;
    logic [9:0]  mac_m;
    int          err_count, samples_checked;
    integer      seed;

    srst_ctrl #(.STRAP_W(4), .HOLD(HOLD)) uut (
        .sys_clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .strap_pins, .gen_clk_sel_125, .ref_clk_enable, .gen_clk_enable, .mac_rxd_in,
        .mac_rx_ctl_in, .mac_rxc_in, .mac_rxd_out, .mac_rx_ctl_out, .mac_rxc_out,
        .core_rst_out, .core_regs_rst_out, .sub_regs_rst_out, .mac_if_rst_out, .cmu_rst_out,
        .ref_clk_avail, .gen_clk_avail, .xtal_en, .strap_latched);
    srst_host h (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);

    always #12.5 sys_clk = ~sys_clk;
    // core-side traffic changes every cycle so idle forcing is visible
    always @(posedge sys_clk) begin
        #2;
        mac_rxd_in    = 8'($random(seed));
        mac_rx_ctl_in = 1'($random(seed));
        mac_rxc_in    = 1'($random(seed));
    end
    // receive path model: one register stage when the core runs
    always @(posedge sys_clk) mac_m <= {mac_rxd_in, mac_rx_ctl_in, mac_rxc_in};

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t pins got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] got;
        h.rd(a, got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t reg %h got %h exp %h", $time, a, got, exp);
        end
    endtask
    // kind: 0 core, 1 reload, 2 plain subsystem; looked at while the pulse runs
    task automatic mid(input int kind);
        repeat (2) @(posedge sys_clk);
        #3;
        chk_pin({3'h0, sub_regs_rst_out, mac_if_rst_out, core_rst_out, core_regs_rst_out,
                cmu_rst_out}, {3'h0, kind != 0, kind != 0, 2'b11,
                !gen_clk_sel_125});
        chk_pin({5'h00, ref_clk_avail, gen_clk_avail, xtal_en}, {5'h00, ref_clk_enable && kind != 1,
                gen_clk_enable && !(kind == 1 && gen_clk_sel_125), 1'b1});
        chk_pin(mac_rxd_out, 8'h00);
        chk_pin({6'h00, mac_rx_ctl_out, mac_rxc_out}, 8'h01);
        if (kind == 0) chk_rd(srst_pkg::ADDR_CORE_CTRL, {12'h800, latched_m});
        else chk_rd(srst_pkg::ADDR_SUB_TRIG, 16'h0001);
    endtask
    // bounded wait for the pulse to end
    task automatic wait_idle();
        for (int n = 0; n < 40 && core_rst_out !== 1'b0; n++) @(posedge sys_clk);
        #2;
        chk_pin({3'h0, core_rst_out, core_regs_rst_out, sub_regs_rst_out, mac_if_rst_out,
                cmu_rst_out}, 8'h00);
        chk_pin({6'h00, ref_clk_avail, gen_clk_avail},
                {6'h00, ref_clk_enable, gen_clk_enable});
        chk_pin(mac_rxd_out, mac_m[9:2]);
        chk_pin({6'h00, mac_rx_ctl_out, mac_rxc_out}, {6'h00, mac_m[1:0]});
    endtask
    task automatic summarize();
        $display("mismatches %0d compares %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(25 * 4000);
        err_count++;
        summarize();
    end
    initial begin
        seed = 32'hb23c;
        err_count = 0;
        samples_checked = 0;
        sys_clk = 1'b0;
        rstn = 1'b0;
        {gen_clk_sel_125, ref_clk_enable, gen_clk_enable} = 3'b011;
        {mac_rxd_in, mac_rx_ctl_in, mac_rxc_in} = 10'h000;
        strap_pins = 4'($random(seed));
        repeat (6) @(posedge sys_clk);
        #2;
        rstn = 1'b1;
        latched_m = strap_pins;
        repeat (2) @(posedge sys_clk);
        #2;
        chk_pin({4'h0, strap_latched}, {4'h0, latched_m});
        chk_rd(srst_pkg::ADDR_RELOAD_EN, 16'h0000);
        chk_rd(16'h1234, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            gen_clk_sel_125 = i[0];
            ref_clk_enable = 1'($random(seed));
            gen_clk_enable = 1'($random(seed));
            wdat = 16'($random(seed)) & 16'h7fff;
            h.wr(srst_pkg::ADDR_RELOAD_EN, 16'h0001);
            h.wr(srst_pkg::ADDR_CORE_CTRL, wdat);
            chk_rd(srst_pkg::ADDR_CORE_CTRL, wdat);
            h.wr(srst_pkg::ADDR_SUB_TRIG, 16'h0000);
            strap_pins = 4'($random(seed));
            h.wr(srst_pkg::ADDR_CORE_CTRL, 16'h8000 | wdat);
            mid(0);
            wait_idle();
            chk_rd(srst_pkg::ADDR_CORE_CTRL, {12'h000, latched_m});
            chk_rd(srst_pkg::ADDR_RELOAD_EN, 16'h0001);
            strap_pins = 4'($random(seed));
            h.wr(srst_pkg::ADDR_SUB_TRIG, 16'h0001);
            latched_m = strap_pins;
            mid(1);
            wait_idle();
            chk_pin({4'h0, strap_latched}, {4'h0, latched_m});
            chk_rd(srst_pkg::ADDR_RELOAD_EN, 16'h0000);
            chk_rd(srst_pkg::ADDR_CORE_CTRL, {12'h000, latched_m});
            h.wr(srst_pkg::ADDR_CORE_CTRL, wdat ^ 16'h7ff0);
            strap_pins = 4'($random(seed));
            h.wr(srst_pkg::ADDR_SUB_TRIG, 16'h0001);
            mid(2);
            wait_idle();
            chk_pin({4'h0, strap_latched}, {4'h0, latched_m});
            chk_rd(srst_pkg::ADDR_SUB_TRIG, 16'h0000);
            chk_rd(srst_pkg::ADDR_CORE_CTRL, {12'h000, latched_m});
        end
        summarize();
    end
endmodule
